// File: bench/host_model.sv
// Host processor model: drives the timer's parallel port through two tasks.
// Assumes the bench calls the tasks just after a falling sys_clk edge.
`timescale 1ns/1ns
module host_model (
    output logic       cs_n,    // Chip select, active low
    output logic       rd_n,    // Read strobe, active low
    output logic       wr_n,    // Write strobe, active low
    output logic [1:0] addr,    // Port address
    output logic [7:0] wdata,   // Bus data towards timer
    input  wire logic       sys_clk, // System clock
    input  wire logic [7:0] rdata,   // Bus data from timer
    input  wire logic       oe       // Timer drive enable
);
    initial {cs_n, rd_n, wr_n, addr, wdata} = 13'h1C00;
    task automatic bus_wr(input logic [1:0] a, input logic [7:0] d, input logic sel_n);
        {cs_n, addr, wdata, wr_n} = {sel_n, a, d, 1'b0};
        repeat (2) @(negedge sys_clk);
        wr_n = 1'b1;
        repeat (2) @(negedge sys_clk);
        // Released bus must not keep showing the byte
        {cs_n, wdata} = {1'b1, ~d};
        // Let an edge pass so a following call never re-drives in this time step
        @(negedge sys_clk);
    endtask : bus_wr
    task automatic bus_rd(input logic [1:0] a, output logic [8:0] q);
        {cs_n, addr, rd_n} = {1'b0, a, 1'b0};
        repeat (3) @(negedge sys_clk);
        q = {oe, rdata};
        rd_n = 1'b1;
        repeat (2) @(negedge sys_clk);
        cs_n = 1'b1;
        @(negedge sys_clk);
    endtask : bus_rd
endmodule : host_model

// File: bench/tb.sv
// Self-checking bench: host model on the port, counter clocks made here.
// Assumes counter clocks far slower than sys_clk; no ticks during bus cycles.
`timescale 1ns/1ns
module tb;
    typedef struct {logic [7:0] ctrl; logic [15:0] cnt; int ticks; logic [15:0] exp; logic out;} row_s;
    logic        sys_clk;
    logic        reset_n;
    logic        chip_sel_n, rd_n, wr_n, data_oe;
    logic  [1:0] addr, ch;
    logic  [7:0] data_in, data_out;
    logic  [2:0] cnt_clk, gate, timer_out;
    logic  [8:0] rq;
    logic [15:0] v;
    int          error_cnt = 0;
    int          checked = 0;
    // Control byte, count, ticks, count after, output after
    // First falling counter clock after the load only transfers the count
    row_s        rows [7] = '{'{8'h74, 16'h0003, 3, 16'h0001, 1'b0}, '{8'hB6, 16'h0005, 3, 16'h0001, 1'b1},
        '{8'h30, 16'h0005, 2, 16'h0004, 1'b0}, '{8'h71, 16'h0010, 2, 16'h0009, 1'b0},
        '{8'hB0, 16'h0003, 4, 16'h0000, 1'b1}, '{8'h38, 16'h0104, 3, 16'h0102, 1'b1},
        '{8'h70, 16'h0100, 2, 16'h00FF, 1'b0}};
    interval_timer interval_timer_i (.sys_clk(sys_clk), .reset_n(reset_n), .chip_sel_n(chip_sel_n), .rd_n(rd_n),
        .wr_n(wr_n), .port_address_hi(addr[1]), .port_address_lo(addr[0]), .data_in(data_in),
        .data_out(data_out), .data_oe(data_oe), .cnt_clk(cnt_clk), .gate(gate), .timer_out(timer_out));
    host_model host_model_i (.sys_clk(sys_clk), .cs_n(chip_sel_n), .rd_n(rd_n), .wr_n(wr_n), .addr(addr),
        .wdata(data_in), .rdata(data_out), .oe(data_oe));
    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    task automatic tick(input logic [1:0] c);
        cnt_clk[c] = 1'b1;
        repeat (2) @(negedge sys_clk);
        cnt_clk[c] = 1'b0;
        repeat (3) @(negedge sys_clk);
    endtask : tick
    task automatic load(input logic [7:0] ctrl, input logic [15:0] cnt);
        host_model_i.bus_wr(2'h3, ctrl, 1'b0);
        host_model_i.bus_wr(ctrl[7:6], cnt[7:0], 1'b0);
        host_model_i.bus_wr(ctrl[7:6], cnt[15:8], 1'b0);
    endtask : load
    // Latch first so a running count reads as one value
    task automatic peek(input logic [1:0] c, output logic [15:0] q);
        host_model_i.bus_wr(2'h3, {c, 6'h00}, 1'b0);
        host_model_i.bus_rd(c, rq);
        q[7:0] = rq[7:0];
        host_model_i.bus_rd(c, rq);
        q[15:8] = rq[7:0];
    endtask : peek
    task automatic end_sim;
        if (error_cnt == 0 && checked > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : end_sim
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        sys_clk = 1'b0;
        forever #10 sys_clk = ~sys_clk;
    end
    initial begin
        #400000;
        error_cnt++;
        end_sim();
    end
    initial begin
        {reset_n, cnt_clk, gate} = 7'h00;
        repeat (8) @(negedge sys_clk);
        reset_n = 1'b1;
        @(negedge sys_clk);
        check("reset out", timer_out, 3'h7);
        check("reset oe", data_oe, 1'b0);
        foreach (rows[i]) begin
            ch = rows[i].ctrl[7:6];
            load(rows[i].ctrl, rows[i].cnt);
            repeat (rows[i].ticks) tick(ch);
            check("row out", timer_out[ch], rows[i].out);
            peek(ch, v);
            check("row count", v, rows[i].exp);
        end
        load(8'h30, 16'h0005);
        gate[0] = 1'b1;
        tick(2'h0);
        tick(2'h0);
        gate[0] = 1'b0;
        peek(2'h0, v);
        check("gated count", v, 16'h0005);
        tick(2'h0);
        peek(2'h0, v);
        check("resumed count", v, 16'h0004);
        host_model_i.bus_wr(2'h0, 8'h55, 1'b1);
        host_model_i.bus_wr(2'h0, 8'h55, 1'b1);
        tick(2'h0);
        peek(2'h0, v);
        check("deselected write", v, 16'h0003);
        host_model_i.bus_rd(2'h3, rq);
        check("control read oe", rq[8], 1'b0);
        host_model_i.bus_wr(2'h3, 8'hF0, 1'b0);
        repeat (2) @(negedge sys_clk);
        check("bad select", timer_out, 3'h4);
        // Reload after terminal count: output stays high until the second byte
        host_model_i.bus_wr(2'h2, 8'h04, 1'b0);
        tick(2'h2);
        check("first byte out", timer_out[2], 1'b1);
        host_model_i.bus_wr(2'h2, 8'h00, 1'b0);
        repeat (2) @(negedge sys_clk);
        check("reloaded out", timer_out[2], 1'b0);
        tick(2'h2);
        peek(2'h2, v);
        check("reloaded count", v, 16'h0004);
        // Hardware strobe: gate rise arms, one-period low pulse at terminal count
        load(8'h7A, 16'h0002);
        gate[1] = 1'b1;
        repeat (3) tick(2'h1);
        check("strobe out", timer_out[1], 1'b0);
        tick(2'h1);
        check("strobe end", timer_out[1], 1'b1);
        end_sim();
    end
endmodule : tb

// File: bench/timer_sva.sv
// Checker for the timer's host port and counter outputs.
// Assumes it is bound to interval_timer and sees only its ports.
`timescale 1ns/1ns
module timer_sva (
    input wire logic       sys_clk,         // System clock
    input wire logic       reset_n,         // Reset, active low
    input wire logic       chip_sel_n,      // Chip select
    input wire logic       rd_n,            // Read strobe
    input wire logic       wr_n,            // Write strobe
    input wire logic       port_address_hi, // Address bit 1
    input wire logic       port_address_lo, // Address bit 0
    input wire logic [7:0] data_in,         // Write data
    input wire logic [7:0] data_out,        // Read data
    input wire logic       data_oe,         // Drive enable
    input wire logic [2:0] cnt_clk,         // Counter clocks
    input wire logic [2:0] gate,            // Gates
    input wire logic [2:0] timer_out        // Outputs
);
    default clocking @(posedge sys_clk);
    endclocking
    default disable iff (!reset_n);
    logic wr_q;
    logic ctrl_wr;
    always_ff @(posedge sys_clk) wr_q <= wr_n;
    assign ctrl_wr = wr_n && !wr_q && !chip_sel_n && port_address_hi && port_address_lo;
    desel_quiet_a: assert property ((chip_sel_n || rd_n) |-> !data_oe)
        else $error("data bus driven without a read");
    wr_no_drive_a: assert property (!wr_n |-> !data_oe)
        else $error("data bus driven during a write");
    ctrl_float_a: assert property ((!chip_sel_n && !rd_n && port_address_hi && port_address_lo)[*2] |-> !data_oe)
        else $error("control address read drove the bus");
    read_drive_a: assert property (!chip_sel_n && !rd_n && wr_n && !(port_address_hi && port_address_lo) |-> data_oe)
        else $error("counter read left the bus floating");
    out_quiet_a: assert property ((wr_n && $stable(cnt_clk) && $stable(gate))[*4] |=> $stable(timer_out))
        else $error("output moved with no counter clock edge");
    mode0_low_a: assert property (ctrl_wr && data_in[7:4] inside {4'h1, 4'h2, 4'h3} &&
        data_in[3:1] == 3'h0 |-> ##[1:2] !timer_out[0]) else $error("mode 0 write left output high");
    strobe_high_a: assert property (ctrl_wr && data_in[7:6] == 2'h0 && data_in[5:4] != 2'h0 &&
        data_in[3:2] == 2'h2 |-> ##[1:2] timer_out[0]) else $error("strobe mode write left output low");
    bad_sel_a: assert property (ctrl_wr && data_in[7:6] == 2'h3 && $stable(cnt_clk) |=> $stable(timer_out)[*2])
        else $error("invalid select changed an output");
    cover property (ctrl_wr && data_in[7:6] == 2'h0);
    cover property ($rose(timer_out[2]));
    cover property (chip_sel_n && !wr_n);
endmodule : timer_sva
bind interval_timer timer_sva timer_sva_i (.sys_clk, .reset_n, .chip_sel_n, .rd_n, .wr_n, .port_address_hi,
    .port_address_lo, .data_in, .data_out, .data_oe, .cnt_clk, .gate, .timer_out);

// File: hdl/interval_timer.sv
// Three-channel interval timer: host port decode and three counter channels.
// Assumes host strobes and counter clocks are synchronous to sys_clk.
`timescale 1ns/1ns
module interval_timer (
    input  wire logic       sys_clk,            // System clock
    input  wire logic       reset_n,            // Synchronous reset, active low
    input  wire logic       chip_sel_n,         // Chip select, active low
    input  wire logic       rd_n,               // Read strobe, active low
    input  wire logic       wr_n,               // Write strobe, active low
    input  wire logic       port_address_hi,    // Port address bit 1
    input  wire logic       port_address_lo,    // Port address bit 0
    input  wire logic [7:0] data_in,            // Data bus input
    output logic      [7:0] data_out,           // Data bus output
    output logic            data_oe,            // Data bus drive enable
    input  wire logic [2:0] cnt_clk,            // Counter clock inputs
    input  wire logic [2:0] gate,               // Gate inputs
    output logic      [2:0] timer_out           // Counter outputs
);
    logic [1:0]  addr;
    logic        wr_d1_q;
    logic        rd_d1_q;
    logic        wr_end;
    logic        rd_end;
    logic [1:0]  sel;
    logic [7:0]  ch_rdata [3];
    logic [7:0]  data_out_q;

    assign addr   = {port_address_hi, port_address_lo};
    assign sel    = data_in[interval_timer_pkg::SEL_HI_BIT:interval_timer_pkg::SEL_LO_BIT];
    // Act on strobe trailing edge, as a write completes when the strobe ends
    assign wr_end = ~wr_d1_q & wr_n & ~chip_sel_n;
    assign rd_end = ~rd_d1_q & rd_n & ~chip_sel_n;

    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            wr_d1_q <= 1'b1;
            rd_d1_q <= 1'b1;
        end else begin
            wr_d1_q <= wr_n | chip_sel_n;
            rd_d1_q <= rd_n | chip_sel_n;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    for (genvar i = 0; i < interval_timer_pkg::NUM_CHANNELS; i++) begin : g_ch
        timer_channel #(
            .COUNT_W (interval_timer_pkg::COUNT_W)
        ) u_ch (
            .sys_clk   (sys_clk),
            .reset_n   (reset_n),
            .cnt_clk   (cnt_clk[i]),
            .gate      (gate[i]),
            .ctrl_we   (wr_end && addr == interval_timer_pkg::ADDR_CONTROL
                        && sel == 2'(i)),
            .ctrl_byte (data_in),
            .data_we   (wr_end && addr == 2'(i)),
            .data_re   (rd_end && addr == 2'(i)),
            .wdata     (data_in),
            .rdata     (ch_rdata[i]),
            .out_q     (timer_out[i])
        );
    end

    // Read data registered; control address reads float
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            data_out_q <= 8'h00;
        end else if (addr != interval_timer_pkg::ADDR_CONTROL) begin
            data_out_q <= ch_rdata[addr];
        end
    end

    assign data_out = data_out_q;
    assign data_oe  = ~chip_sel_n & ~rd_n & wr_n
                      & (addr != interval_timer_pkg::ADDR_CONTROL);
endmodule : interval_timer

// File: hdl/interval_timer_pkg.sv
// Constants shared by the three-channel interval timer and its counter channel.
// Assumes a single system clock; counter clocks and gates are synchronous inputs.
package interval_timer_pkg;
    localparam int          NUM_CHANNELS    = 3;
    localparam int          COUNT_W         = 16;
    // Port address codes
    localparam logic [1:0]  ADDR_CONTROL    = 2'h3;
    // Control byte field positions
    localparam int          SEL_HI_BIT      = 7;
    localparam int          SEL_LO_BIT      = 6;
    localparam int          ACC_HI_BIT      = 5;
    localparam int          ACC_LO_BIT      = 4;
    localparam int          MODE_HI_BIT     = 3;
    localparam int          MODE_LO_BIT     = 1;
    localparam int          DECIMAL_BIT     = 0;
    localparam logic [1:0]  SEL_INVALID     = 2'h3;
    // Byte access codes
    localparam logic [1:0]  ACC_LATCH       = 2'h0;
    localparam logic [1:0]  ACC_LOW_ONLY    = 2'h1;
    localparam logic [1:0]  ACC_HIGH_ONLY   = 2'h2;
    localparam logic [1:0]  ACC_LOW_HIGH    = 2'h3;
    localparam logic [7:0]  CTRL_RESET      = 8'h00;
    localparam logic [15:0] COUNT_RESET     = 16'h0000;
    localparam logic [3:0]  DECADE_MAX      = 4'h9;

    typedef enum logic [2:0] {
        MODE_TC_IRQ    = 3'b000,
        MODE_ONE_SHOT  = 3'b001,
        MODE_RATE      = 3'b010,
        MODE_SQUARE    = 3'b011,
        MODE_SW_STROBE = 3'b100,
        MODE_HW_STROBE = 3'b101
    } timer_mode_e;
endpackage : interval_timer_pkg

// File: hdl/timer_channel.sv
// One 16-bit down counter channel with mode logic and read latch.
// Assumes counter clock and gate are synchronous to sys_clk and slower than it.
`timescale 1ns/1ns
module timer_channel #(
    parameter int COUNT_W = 16
) (
    input  wire logic               sys_clk,      // System clock
    input  wire logic               reset_n,      // Synchronous reset
    input  wire logic               cnt_clk,      // Counter clock input
    input  wire logic               gate,         // Gate input
    input  wire logic               ctrl_we,      // Control byte for this channel
    input  wire logic [7:0]         ctrl_byte,    // Control byte value
    input  wire logic               data_we,      // Count byte write
    input  wire logic               data_re,      // Count byte read done
    input  wire logic [7:0]         wdata,        // Write data
    output logic      [7:0]         rdata,        // Read data
    output logic                    out_q         // Counter output
);
    // Decade logic and byte lanes are fixed at 16 bits
    if (COUNT_W != interval_timer_pkg::COUNT_W) begin : g_bad_width
        $error("timer_channel supports 16-bit counters only");
    end

    logic [1:0]             acc_q;
    logic [2:0]             mode_q;
    logic                   dec_q;
    logic [COUNT_W-1:0]     init_q;      // Loaded count
    logic [COUNT_W-1:0]     cnt_q;       // Working count
    logic [COUNT_W-1:0]     latch_q;     // Read latch
    logic                   latched_q;
    logic                   wr_hi_q;     // Next write goes to high byte
    logic                   rd_hi_q;
    logic                   armed_q;     // Count loaded, counting allowed
    logic                   pend_q;      // New count waits for reload point
    logic                   trig_q;      // Gate trigger seen
    logic                   clk_d1_q;
    logic                   gate_d1_q;
    logic                   fall;
    logic                   gate_rise;
    logic                   gate_fall;
    logic                   load_done;
    logic [COUNT_W-1:0]     new_init;
    logic [COUNT_W-1:0]     dec1;
    logic [COUNT_W-1:0]     dec2;
    logic [COUNT_W-1:0]     reload_val;
    logic [2:0]             mode_n;

    // Decade-aware decrement by one
    function automatic logic [15:0] count_down(input logic [15:0] v, input logic bcd);
        logic [15:0] r;
        r = v;
        if (!bcd) begin
            r = v - 16'h0001;
        end else begin
            for (int i = 0; i < 4; i++) begin
                if (r[i*4 +: 4] != 4'h0) begin
                    r[i*4 +: 4] = r[i*4 +: 4] - 4'h1;
                    break;
                end
                r[i*4 +: 4] = interval_timer_pkg::DECADE_MAX;
            end
        end
        return r;
    endfunction : count_down

    assign fall      = clk_d1_q & ~cnt_clk;
    assign gate_rise = gate & ~gate_d1_q;
    assign gate_fall = ~gate & gate_d1_q;
    assign dec1      = count_down(cnt_q, dec_q);
    assign dec2      = count_down(dec1, dec_q);
    assign mode_n    = mode_q[1] ? {1'b0, mode_q[1:0]} : mode_q;
    assign load_done = data_we && (acc_q != interval_timer_pkg::ACC_LOW_HIGH || wr_hi_q);

    always_comb begin
        new_init = init_q;
        case (acc_q)
            interval_timer_pkg::ACC_LOW_ONLY:  new_init = {8'h00, wdata};
            interval_timer_pkg::ACC_HIGH_ONLY: new_init = {wdata, 8'h00};
            interval_timer_pkg::ACC_LOW_HIGH:  new_init = wr_hi_q ? {wdata, init_q[7:0]}
                                                                  : {init_q[15:8], wdata};
            default:                           new_init = init_q;
        endcase
    end

    // Odd square-wave count drops to even on reload
    assign reload_val = (mode_n == 3'(interval_timer_pkg::MODE_SQUARE) && !out_q)
                        ? {init_q[15:1], 1'b0} : init_q;

    ////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            clk_d1_q  <= 1'b0;
            gate_d1_q <= 1'b0;
        end else begin
            clk_d1_q  <= cnt_clk;
            gate_d1_q <= gate;
        end
    end

    // Control word and host byte sequencing
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            acc_q   <= interval_timer_pkg::ACC_LOW_HIGH;
            mode_q  <= 3'(interval_timer_pkg::MODE_TC_IRQ);
            dec_q   <= 1'b0;
            init_q  <= interval_timer_pkg::COUNT_RESET;
            wr_hi_q <= 1'b0;
        end else if (ctrl_we && ctrl_byte[interval_timer_pkg::ACC_HI_BIT:interval_timer_pkg::ACC_LO_BIT]
                     != interval_timer_pkg::ACC_LATCH) begin
            acc_q   <= ctrl_byte[interval_timer_pkg::ACC_HI_BIT:interval_timer_pkg::ACC_LO_BIT];
            mode_q  <= ctrl_byte[interval_timer_pkg::MODE_HI_BIT:interval_timer_pkg::MODE_LO_BIT];
            dec_q   <= ctrl_byte[interval_timer_pkg::DECIMAL_BIT];
            wr_hi_q <= 1'b0;
        end else if (data_we) begin
            init_q  <= new_init;
            wr_hi_q <= (acc_q == interval_timer_pkg::ACC_LOW_HIGH) ? ~wr_hi_q : 1'b0;
        end
    end

    // Read latch: snapshot lets the host read a running count undisturbed
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            latch_q   <= interval_timer_pkg::COUNT_RESET;
            latched_q <= 1'b0;
            rd_hi_q   <= 1'b0;
        end else begin
            if (ctrl_we && ctrl_byte[interval_timer_pkg::ACC_HI_BIT:interval_timer_pkg::ACC_LO_BIT]
                == interval_timer_pkg::ACC_LATCH) begin
                latch_q   <= cnt_q;
                latched_q <= 1'b1;
            end else if (ctrl_we) begin
                latched_q <= 1'b0;
                rd_hi_q   <= 1'b0;
            end
            if (data_re) begin
                if (acc_q == interval_timer_pkg::ACC_LOW_HIGH) begin
                    rd_hi_q <= ~rd_hi_q;
                    if (rd_hi_q) latched_q <= 1'b0;
                end else begin
                    latched_q <= 1'b0;
                end
            end
        end
    end

    always_comb begin
        logic [15:0] src;
        src = latched_q ? latch_q : cnt_q;
        case (acc_q)
            interval_timer_pkg::ACC_HIGH_ONLY: rdata = src[15:8];
            interval_timer_pkg::ACC_LOW_HIGH:  rdata = rd_hi_q ? src[15:8] : src[7:0];
            default:                           rdata = src[7:0];
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // Counting engine and output per mode
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            cnt_q   <= interval_timer_pkg::COUNT_RESET;
            out_q   <= 1'b1;
            armed_q <= 1'b0;
            pend_q  <= 1'b0;
            trig_q  <= 1'b0;
        end else if (ctrl_we && ctrl_byte[interval_timer_pkg::ACC_HI_BIT:interval_timer_pkg::ACC_LO_BIT]
                     != interval_timer_pkg::ACC_LATCH) begin
            out_q   <= (ctrl_byte[interval_timer_pkg::MODE_HI_BIT:interval_timer_pkg::MODE_LO_BIT]
                        != 3'(interval_timer_pkg::MODE_TC_IRQ));
            armed_q <= 1'b0;
            pend_q  <= 1'b0;
            trig_q  <= 1'b0;
        end else begin
            if (data_we) begin
                case (mode_n)
                    3'(interval_timer_pkg::MODE_TC_IRQ), 3'(interval_timer_pkg::MODE_SW_STROBE): begin
                        armed_q <= load_done;
                        pend_q  <= load_done;
                        out_q   <= (mode_n == 3'(interval_timer_pkg::MODE_SW_STROBE)) ? 1'b1
                                   : (load_done ? 1'b0 : out_q);
                    end
                    default: begin
                        if (load_done) begin
                            pend_q <= 1'b1;
                            if (!armed_q && (mode_n == 3'(interval_timer_pkg::MODE_RATE)
                                          || mode_n == 3'(interval_timer_pkg::MODE_SQUARE)))
                                armed_q <= 1'b1;
                        end
                    end
                endcase
            end
            if (gate_rise) trig_q <= 1'b1;
            case (mode_n)
                3'(interval_timer_pkg::MODE_TC_IRQ): begin
                    if (fall && armed_q && !data_we) begin
                        if (pend_q) begin
                            cnt_q  <= init_q;
                            pend_q <= 1'b0;
                        end else if (!gate) begin
                            cnt_q <= dec1;
                            if (dec1 == interval_timer_pkg::COUNT_RESET) out_q <= 1'b1;
                        end
                    end
                end
                3'(interval_timer_pkg::MODE_ONE_SHOT): begin
                    if (gate_fall) trig_q <= 1'b1;
                    if (fall && trig_q) begin
                        cnt_q  <= init_q;
                        out_q  <= 1'b0;
                        trig_q <= gate_rise | gate_fall;               // New trigger wins over consume
                        pend_q <= 1'b0;
                    end else if (fall && !out_q) begin
                        cnt_q <= dec1;
                        if (dec1 == interval_timer_pkg::COUNT_RESET) out_q <= 1'b1;
                    end
                end
                3'(interval_timer_pkg::MODE_RATE): begin
                    if (gate) begin
                        out_q  <= 1'b1;
                        pend_q <= 1'b1;
                    end else if (fall && armed_q) begin
                        if (pend_q || !out_q) begin
                            cnt_q  <= init_q;
                            pend_q <= 1'b0;
                            out_q  <= 1'b1;
                        end else begin
                            cnt_q <= dec1;
                            if (dec1 == 16'h0001) out_q <= 1'b0;
                        end
                    end
                end
                3'(interval_timer_pkg::MODE_SQUARE): begin
                    if (gate) begin
                        out_q  <= 1'b1;
                        pend_q <= 1'b1;
                    end else if (fall && armed_q) begin
                        if (pend_q) begin
                            cnt_q  <= {init_q[15:1], 1'b0} + {15'h0000, init_q[0]};
                            pend_q <= 1'b0;
                            out_q  <= 1'b1;
                        end else if (dec2 == interval_timer_pkg::COUNT_RESET
                                     || dec1 == interval_timer_pkg::COUNT_RESET) begin
                            out_q <= ~out_q;
                            cnt_q <= out_q ? {init_q[15:1], 1'b0} : reload_val + {15'h0000, init_q[0]};
                        end else begin
                            cnt_q <= dec2;
                        end
                    end
                end
                3'(interval_timer_pkg::MODE_SW_STROBE), 3'(interval_timer_pkg::MODE_HW_STROBE): begin
                    if (mode_n == 3'(interval_timer_pkg::MODE_HW_STROBE) && gate_rise)
                        armed_q <= 1'b1;
                    if (mode_n == 3'(interval_timer_pkg::MODE_SW_STROBE) && gate && armed_q) begin
                        pend_q <= 1'b1;
                        out_q  <= 1'b1;
                    end else if (fall && !out_q) begin
                        out_q <= 1'b1;
                    end else if (fall && armed_q && !data_we) begin
                        if (pend_q || (trig_q && mode_n == 3'(interval_timer_pkg::MODE_HW_STROBE))) begin
                            cnt_q  <= init_q;
                            pend_q <= 1'b0;
                            trig_q <= gate_rise;
                        end else if (cnt_q != interval_timer_pkg::COUNT_RESET) begin
                            cnt_q <= dec1;
                            if (dec1 == interval_timer_pkg::COUNT_RESET) begin
                                out_q   <= 1'b0;
                                // A trigger in the terminal cycle keeps the channel armed
                                armed_q <= gate_rise && mode_n == 3'(interval_timer_pkg::MODE_HW_STROBE);
                            end
                        end
                    end
                end
                default: ;
            endcase
        end
    end
endmodule : timer_channel
